// ### rtl/nibble_xfer_pkg.sv
// Purpose: shared constants and types of the nibble transfer and exchange unit
// Assumes: 4-bit register nibbles, 8-bit data memory address, 13-bit counter
// Notes:   table address is 15 bits wide so the widest absolute form fits
package nibble_xfer_pkg;

  localparam int NIB_W   = 4;
  localparam int DADDR_W = 8;
  localparam int PC_W    = 13;
  localparam int TADDR_W = 15;
  localparam int NIBBLES = 16;

  // nibble slots in the register file; alternate bank is slot + 8
  localparam logic [3:0] IDX_A = 4'h0;
  localparam logic [3:0] IDX_X = 4'h1;
  localparam logic [3:0] IDX_L = 4'h2;
  localparam logic [3:0] IDX_H = 4'h3;
  localparam logic [3:0] IDX_E = 4'h4;
  localparam logic [3:0] IDX_D = 4'h5;
  localparam logic [3:0] IDX_C = 4'h6;
  localparam logic [3:0] IDX_B = 4'h7;

  localparam logic [3:0] NIB_RESET   = 4'h0;
  localparam logic       CARRY_RESET = 1'b0;
  localparam logic [7:0] PAGE_LAST   = 8'hFF;
  localparam logic [3:0] L_END_INC   = 4'h0;
  localparam logic [3:0] L_END_DEC   = 4'hF;

  typedef enum logic [4:0] {
    OP_NOP, OP_LD_MEM, OP_LD_MEM_PAIR, OP_ST_MEM, OP_ST_MEM_PAIR,
    OP_MOV_A_REG, OP_MOV_XA_PAIR, OP_MOV_REG_A, OP_MOV_PAIR_XA,
    OP_SWAP_IND, OP_SWAP_IND_PAIR, OP_SWAP_DIR, OP_SWAP_DIR_PAIR,
    OP_SWAP_REG, OP_SWAP_PAIR,
    OP_TBL_PC_DE, OP_TBL_PC_XA, OP_TBL_BC_XA, OP_TBL_BC_DE,
    OP_BIT_LD, OP_BIT_ST, OP_ADDS_IMM
  } op_t;

  typedef enum logic [2:0] {PTR_HL, PTR_HL_INC, PTR_HL_DEC, PTR_DE, PTR_DL} ptr_t;

  typedef enum logic [1:0] {BIT_FMEM, BIT_PMEM, BIT_HMEM} bitmode_t;

  typedef enum logic [2:0] {S_IDLE, S_RD, S_CAP, S_WR, S_PRD, S_PCAP} state_t;

endpackage

// ### rtl/nibble_regfile.sv
// Purpose: two banks of four nibble pairs, any subset written per cycle
// Assumes: writes are single-cycle, contents always visible from flops
// Notes:   exchanges need up to four slots written in the same edge
`timescale 1ns/1ps
module nibble_regfile #(
  parameter int ENTRIES = nibble_xfer_pkg::NIBBLES,
  parameter int WIDTH   = nibble_xfer_pkg::NIB_W
) (
  // clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     arst_n_i,
  input  wire logic                     ce_i,
  // write side
  input  wire logic [ENTRIES-1:0]       we_i,
  input  wire logic [ENTRIES*WIDTH-1:0] wdata_i,
  // read side
  output logic      [ENTRIES*WIDTH-1:0] rdata_o
);

  if (ENTRIES != nibble_xfer_pkg::NIBBLES || WIDTH != nibble_xfer_pkg::NIB_W) begin : g_chk
    $error("nibble_regfile: only 16 entries of 4 bits are supported");
  end

  for (genvar i = 0; i < ENTRIES; i++) begin : g_ent
    logic [WIDTH-1:0] ent_q;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        ent_q <= nibble_xfer_pkg::NIB_RESET;
      end else if (ce_i && we_i[i]) begin
        ent_q <= wdata_i[i*WIDTH +: WIDTH];
      end
    end
    assign rdata_o[i*WIDTH +: WIDTH] = ent_q;
  end

endmodule

// ### rtl/nibble_xfer_unit.sv
// Purpose: moves, exchanges, table reads, carry bit copies, add-with-skip
// Assumes: data and program memory return read data one cycle after the strobe
// Notes:   a skipped operation runs its cycles but every write is suppressed
`timescale 1ns/1ps
// Operation
// - pair load from even direct address
// - accumulator store to any direct address
// - pair store to even direct address
// - any main-bank nibble register (slots 0 to 7) into accumulator
// - any pair into accumulator pair
// - accumulator into non-accumulator nibble register
// - accumulator pair into non-accumulator pair
// - accumulator swaps with pointer-addressed nibble
// - post-increment low pointer, skip at zero
// - post-decrement low pointer, skip at all ones
// - pair swap at pointer, low bit forced
// - direct swap, pair form even address
// - accumulator swaps with another nibble register
// - accumulator pair swaps with any pair
// - counter page plus pair reads table byte
// - last page byte reads next page
// - table reads leave counter untouched
// - absolute table address, 13 bits
// - absolute table address from third, second
// - memory bit copied into carry flag
// - carry flag copied into one memory bit
// - add immediate, skip on carry, carry kept
module nibble_xfer_unit (
  // clock and reset
  input  wire logic                        CORE_CLK_I,
  input  wire logic                        ARST_N_I,
  input  wire logic                        CE_I,
  // operation request
  input  wire logic                        OP_VALID_I,
  output logic                             OP_READY_O,
  input  wire nibble_xfer_pkg::op_t        OP_CODE_I,
  input  wire logic [2:0]                  OP_REG_I,
  input  wire logic [2:0]                  OP_PAIR_I,
  input  wire nibble_xfer_pkg::ptr_t       OP_PTR_I,
  input  wire nibble_xfer_pkg::bitmode_t   OP_BITMODE_I,
  input  wire logic [7:0]                  OP_ADDR_I,
  input  wire logic [1:0]                  OP_BIT_I,
  input  wire logic [3:0]                  OP_IMM_I,
  input  wire logic [12:0]                 PC_I,
  // completion
  output logic                             OP_DONE_O,
  output logic                             SKIP_O,
  // data memory
  output logic      [7:0]                  DMEM_ADDR_O,
  output logic                             DMEM_RD_O,
  output logic                             DMEM_WR_O,
  output logic      [3:0]                  DMEM_WDATA_O,
  input  wire logic [3:0]                  DMEM_RDATA_I,
  // program memory
  output logic      [14:0]                 PMEM_ADDR_O,
  output logic                             PMEM_RD_O,
  input  wire logic [7:0]                  PMEM_RDATA_I,
  // state view
  output logic      [3:0]                  ACC_O,
  output logic      [3:0]                  EXT_O,
  output logic                             CARRY_O
);

  nibble_xfer_pkg::state_t state_q;
  nibble_xfer_pkg::op_t    op_q;
  nibble_xfer_pkg::ptr_t   ptr_q;
  logic [7:0]  addr_q;
  logic [14:0] taddr_q;
  logic [3:0]  wdata_q;
  logic [1:0]  bit_q;
  logic        nib_q;
  logic        squash_q;
  logic        skip_q;
  logic        hit_q;
  logic        done_q;
  logic        carry_q;

  logic [63:0] rf_q;
  logic [15:0] rf_we;
  logic [63:0] rf_wd;

  function automatic logic [3:0] pick(input logic [63:0] v, input logic [3:0] i);
    return v[{i, 2'b00} +: 4];
  endfunction

  // named register views
  wire logic [3:0] acc     = pick(rf_q, nibble_xfer_pkg::IDX_A);
  wire logic [3:0] ext     = pick(rf_q, nibble_xfer_pkg::IDX_X);
  wire logic [3:0] l_nib   = pick(rf_q, nibble_xfer_pkg::IDX_L);
  wire logic [3:0] h_nib   = pick(rf_q, nibble_xfer_pkg::IDX_H);
  wire logic [3:0] e_nib   = pick(rf_q, nibble_xfer_pkg::IDX_E);
  wire logic [3:0] d_nib   = pick(rf_q, nibble_xfer_pkg::IDX_D);
  wire logic [3:0] c_nib   = pick(rf_q, nibble_xfer_pkg::IDX_C);
  wire logic [3:0] b_nib   = pick(rf_q, nibble_xfer_pkg::IDX_B);
  wire logic [3:0] reg_idx = {1'b0, OP_REG_I};
  wire logic [3:0] p_lo    = {OP_PAIR_I, 1'b0};
  wire logic [3:0] p_hi    = {OP_PAIR_I, 1'b1};
  wire logic [3:0] reg_val = pick(rf_q, reg_idx);
  wire logic [3:0] p_lo_v  = pick(rf_q, p_lo);
  wire logic [3:0] p_hi_v  = pick(rf_q, p_hi);

  // request decode
  wire logic accept  = OP_VALID_I && CE_I && (state_q == nibble_xfer_pkg::S_IDLE);
  wire logic go      = accept && !skip_q;
  wire logic is_st   = OP_CODE_I inside {nibble_xfer_pkg::OP_ST_MEM,
                                         nibble_xfer_pkg::OP_ST_MEM_PAIR};
  wire logic is_rd   = OP_CODE_I inside {nibble_xfer_pkg::OP_LD_MEM,
                         nibble_xfer_pkg::OP_LD_MEM_PAIR, nibble_xfer_pkg::OP_SWAP_IND,
                         nibble_xfer_pkg::OP_SWAP_IND_PAIR, nibble_xfer_pkg::OP_SWAP_DIR,
                         nibble_xfer_pkg::OP_SWAP_DIR_PAIR, nibble_xfer_pkg::OP_BIT_LD,
                         nibble_xfer_pkg::OP_BIT_ST};
  wire logic is_tbl  = OP_CODE_I inside {nibble_xfer_pkg::OP_TBL_PC_DE,
                         nibble_xfer_pkg::OP_TBL_PC_XA, nibble_xfer_pkg::OP_TBL_BC_XA,
                         nibble_xfer_pkg::OP_TBL_BC_DE};
  wire logic q_pair  = op_q inside {nibble_xfer_pkg::OP_LD_MEM_PAIR,
                         nibble_xfer_pkg::OP_ST_MEM_PAIR, nibble_xfer_pkg::OP_SWAP_IND_PAIR,
                         nibble_xfer_pkg::OP_SWAP_DIR_PAIR};
  wire logic q_swap  = op_q inside {nibble_xfer_pkg::OP_SWAP_IND,
                         nibble_xfer_pkg::OP_SWAP_IND_PAIR, nibble_xfer_pkg::OP_SWAP_DIR,
                         nibble_xfer_pkg::OP_SWAP_DIR_PAIR};
  wire logic q_load  = op_q inside {nibble_xfer_pkg::OP_LD_MEM,
                                    nibble_xfer_pkg::OP_LD_MEM_PAIR};
  wire logic q_step  = (op_q == nibble_xfer_pkg::OP_SWAP_IND) &&
                       (ptr_q inside {nibble_xfer_pkg::PTR_HL_INC, nibble_xfer_pkg::PTR_HL_DEC});

  // data memory address forms
  wire logic [7:0] ind_addr = (OP_PTR_I == nibble_xfer_pkg::PTR_DE) ? {d_nib, e_nib} :
                              (OP_PTR_I == nibble_xfer_pkg::PTR_DL) ? {d_nib, l_nib} :
                              {h_nib, l_nib};
  wire logic [7:0] bit_addr = (OP_BITMODE_I == nibble_xfer_pkg::BIT_PMEM) ?
                              {OP_ADDR_I[7:2], l_nib[3:2]} :
                              (OP_BITMODE_I == nibble_xfer_pkg::BIT_HMEM) ?
                              {h_nib, OP_ADDR_I[3:0]} : OP_ADDR_I;
  wire logic [1:0] bit_sel  = (OP_BITMODE_I == nibble_xfer_pkg::BIT_PMEM) ? l_nib[1:0]
                                                                           : OP_BIT_I;
  wire logic [7:0] even_dir = {OP_ADDR_I[7:1], 1'b0};
  wire logic [7:0] mem_addr =
    (OP_CODE_I inside {nibble_xfer_pkg::OP_LD_MEM_PAIR, nibble_xfer_pkg::OP_ST_MEM_PAIR,
                       nibble_xfer_pkg::OP_SWAP_DIR_PAIR}) ? even_dir :
    (OP_CODE_I == nibble_xfer_pkg::OP_SWAP_IND) ? ind_addr :
    (OP_CODE_I == nibble_xfer_pkg::OP_SWAP_IND_PAIR) ? {h_nib, l_nib[3:1], 1'b0} :
    (OP_CODE_I inside {nibble_xfer_pkg::OP_BIT_LD, nibble_xfer_pkg::OP_BIT_ST}) ? bit_addr :
    OP_ADDR_I;

  // table address forms; counter is only read, never written
  wire logic       last_b   = (PC_I[7:0] == nibble_xfer_pkg::PAGE_LAST);
  wire logic [4:0] page     = PC_I[12:8] + {4'h0, last_b};
  wire logic [14:0] tbl_addr =
    (OP_CODE_I == nibble_xfer_pkg::OP_TBL_PC_DE) ? {2'h0, page, d_nib, e_nib} :
    (OP_CODE_I == nibble_xfer_pkg::OP_TBL_PC_XA) ? {2'h0, page, ext, acc} :
    (OP_CODE_I == nibble_xfer_pkg::OP_TBL_BC_XA) ? {2'h0, b_nib[0], c_nib, ext, acc} :
    {b_nib[2:0], c_nib, d_nib, e_nib};

  wire logic [4:0] adds_sum = {1'b0, acc} + {1'b0, OP_IMM_I};
  wire logic [3:0] l_next   = (ptr_q == nibble_xfer_pkg::PTR_HL_INC) ? l_nib + 4'h1
                                                                      : l_nib - 4'h1;
  wire logic [3:0] cap_idx  = nib_q ? nibble_xfer_pkg::IDX_X : nibble_xfer_pkg::IDX_A;
  wire logic [3:0] cap_old  = nib_q ? ext : acc;
  wire logic [3:0] bit_mask = 4'h1 << bit_q;
  wire logic [3:0] bit_put  = (DMEM_RDATA_I & ~bit_mask) | (carry_q ? bit_mask : 4'h0);
  wire logic       more     = q_pair && !nib_q;
  wire logic       cap_en   = (state_q == nibble_xfer_pkg::S_CAP) && !squash_q;

  // register file writes
  always_comb begin
    rf_we = 16'h0000;
    rf_wd = 64'h0;
    if (go) begin
      case (OP_CODE_I)
        nibble_xfer_pkg::OP_MOV_A_REG: begin
          rf_we[0] = 1'b1;
          rf_wd[3:0] = reg_val;
        end
        nibble_xfer_pkg::OP_MOV_XA_PAIR: begin
          rf_we[1:0] = 2'h3;
          rf_wd[7:0] = {p_hi_v, p_lo_v};
        end
        nibble_xfer_pkg::OP_MOV_REG_A: begin
          rf_we[reg_idx] = (OP_REG_I != 3'h0);
          rf_wd[{reg_idx, 2'b00} +: 4] = acc;
        end
        nibble_xfer_pkg::OP_MOV_PAIR_XA: begin
          rf_we[p_lo] = (OP_PAIR_I != 3'h0);
          rf_we[p_hi] = (OP_PAIR_I != 3'h0);
          rf_wd[{p_lo, 2'b00} +: 4] = acc;
          rf_wd[{p_hi, 2'b00} +: 4] = ext;
        end
        nibble_xfer_pkg::OP_SWAP_REG: begin
          if (OP_REG_I != 3'h0) begin
            rf_we[reg_idx] = 1'b1;
            rf_wd[{reg_idx, 2'b00} +: 4] = acc;
            rf_we[0] = 1'b1;
            rf_wd[3:0] = reg_val;
          end
        end
        nibble_xfer_pkg::OP_SWAP_PAIR: begin
          rf_we[p_lo] = 1'b1;
          rf_we[p_hi] = 1'b1;
          rf_wd[{p_lo, 2'b00} +: 4] = acc;
          rf_wd[{p_hi, 2'b00} +: 4] = ext;
          rf_we[1:0] = 2'h3;
          rf_wd[7:0] = {p_hi_v, p_lo_v};
        end
        nibble_xfer_pkg::OP_ADDS_IMM: begin
          rf_we[0] = 1'b1;
          rf_wd[3:0] = adds_sum[3:0];
        end
        default: begin
        end
      endcase
    end
    if (cap_en && (q_load || q_swap)) begin
      rf_we[cap_idx] = 1'b1;
      rf_wd[{cap_idx, 2'b00} +: 4] = DMEM_RDATA_I;
    end
    if (cap_en && q_step) begin
      rf_we[nibble_xfer_pkg::IDX_L] = 1'b1;
      rf_wd[{nibble_xfer_pkg::IDX_L, 2'b00} +: 4] = l_next;
    end
    if ((state_q == nibble_xfer_pkg::S_PCAP) && !squash_q) begin
      rf_we[1:0] = 2'h3;
      rf_wd[7:0] = {PMEM_RDATA_I[7:4], PMEM_RDATA_I[3:0]};
    end
  end

  nibble_regfile u_regs (
    .clk_i    (CORE_CLK_I),
    .arst_n_i (ARST_N_I),
    .ce_i     (CE_I),
    .we_i     (rf_we),
    .wdata_i  (rf_wd),
    .rdata_o  (rf_q)
  );

  // sequencer: a pair is walked low nibble first, one read/write per cycle
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_q  <= nibble_xfer_pkg::S_IDLE;
      op_q     <= nibble_xfer_pkg::OP_NOP;
      ptr_q    <= nibble_xfer_pkg::PTR_HL;
      addr_q   <= 8'h00;
      taddr_q  <= 15'h0000;
      wdata_q  <= 4'h0;
      bit_q    <= 2'h0;
      nib_q    <= 1'b0;
      squash_q <= 1'b0;
      skip_q   <= 1'b0;
      hit_q    <= 1'b0;
      done_q   <= 1'b0;
      carry_q  <= nibble_xfer_pkg::CARRY_RESET;
    end else if (CE_I) begin
      done_q <= 1'b0;
      case (state_q)
        nibble_xfer_pkg::S_IDLE: begin
          if (accept) begin
            op_q     <= OP_CODE_I;
            ptr_q    <= OP_PTR_I;
            addr_q   <= mem_addr;
            taddr_q  <= tbl_addr;
            bit_q    <= bit_sel;
            wdata_q  <= acc;
            nib_q    <= 1'b0;
            hit_q    <= 1'b0;
            squash_q <= skip_q;
            skip_q   <= 1'b0;
            if (is_st) begin
              state_q <= nibble_xfer_pkg::S_WR;
            end else if (is_rd) begin
              state_q <= nibble_xfer_pkg::S_RD;
            end else if (is_tbl) begin
              state_q <= nibble_xfer_pkg::S_PRD;
            end else begin
              done_q <= 1'b1;
              skip_q <= go && (OP_CODE_I == nibble_xfer_pkg::OP_ADDS_IMM) &&
                        adds_sum[4];
            end
          end
        end
        nibble_xfer_pkg::S_RD: begin
          state_q <= nibble_xfer_pkg::S_CAP;
        end
        nibble_xfer_pkg::S_CAP: begin
          if (op_q == nibble_xfer_pkg::OP_BIT_LD) begin
            carry_q <= squash_q ? carry_q : DMEM_RDATA_I[bit_q];
            state_q <= nibble_xfer_pkg::S_IDLE;
            done_q  <= 1'b1;
          end else if (op_q == nibble_xfer_pkg::OP_BIT_ST) begin
            wdata_q <= bit_put;
            state_q <= nibble_xfer_pkg::S_WR;
          end else if (q_swap) begin
            wdata_q <= cap_old;
            hit_q   <= q_step && (l_next == ((ptr_q == nibble_xfer_pkg::PTR_HL_INC) ?
                       nibble_xfer_pkg::L_END_INC : nibble_xfer_pkg::L_END_DEC));
            state_q <= nibble_xfer_pkg::S_WR;
          end else if (more) begin
            nib_q   <= 1'b1;
            addr_q  <= addr_q + 8'h01;
            state_q <= nibble_xfer_pkg::S_RD;
          end else begin
            state_q <= nibble_xfer_pkg::S_IDLE;
            done_q  <= 1'b1;
          end
        end
        nibble_xfer_pkg::S_WR: begin
          if (more) begin
            nib_q   <= 1'b1;
            addr_q  <= addr_q + 8'h01;
            wdata_q <= ext;
            state_q <= q_swap ? nibble_xfer_pkg::S_RD : nibble_xfer_pkg::S_WR;
          end else begin
            state_q <= nibble_xfer_pkg::S_IDLE;
            done_q  <= 1'b1;
            skip_q  <= hit_q && !squash_q;
          end
        end
        nibble_xfer_pkg::S_PRD: begin
          state_q <= nibble_xfer_pkg::S_PCAP;
        end
        nibble_xfer_pkg::S_PCAP: begin
          state_q <= nibble_xfer_pkg::S_IDLE;
          done_q  <= 1'b1;
        end
        default: begin
          state_q <= nibble_xfer_pkg::S_IDLE;
        end
      endcase
    end
  end

  assign OP_READY_O   = (state_q == nibble_xfer_pkg::S_IDLE);
  assign OP_DONE_O    = done_q;
  assign SKIP_O       = skip_q;
  assign DMEM_ADDR_O  = addr_q;
  assign DMEM_RD_O    = (state_q == nibble_xfer_pkg::S_RD);
  assign DMEM_WR_O    = (state_q == nibble_xfer_pkg::S_WR) && !squash_q;
  assign DMEM_WDATA_O = wdata_q;
  assign PMEM_ADDR_O  = taddr_q;
  assign PMEM_RD_O    = (state_q == nibble_xfer_pkg::S_PRD);
  assign ACC_O        = acc;
  assign EXT_O        = ext;
  assign CARRY_O      = carry_q;

  // checks; an attempt is dropped whenever the clock enable goes low
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!ARST_N_I || !CE_I);

  wire logic [3:0] l_now = l_nib;

  sequence s_take(nibble_xfer_pkg::op_t o);
    accept && !skip_q && OP_CODE_I == o;
  endsequence

  sequence s_pair_read;
    DMEM_RD_O && !DMEM_ADDR_O[0] ##2 DMEM_RD_O && DMEM_ADDR_O[0];
  endsequence

  a_pair_load_addr : assert property (s_take(nibble_xfer_pkg::OP_LD_MEM_PAIR) |=>
    s_pair_read ##2 (ACC_O == $past(DMEM_RDATA_I, 3) && EXT_O == $past(DMEM_RDATA_I)))
    else $error("pair load order wrong");

  a_store_nibble : assert property (s_take(nibble_xfer_pkg::OP_ST_MEM) |=>
    DMEM_WR_O && DMEM_ADDR_O == $past(OP_ADDR_I) && DMEM_WDATA_O == $past(acc))
    else $error("store wrote wrong place or data");

  a_pair_store : assert property (s_take(nibble_xfer_pkg::OP_ST_MEM_PAIR) |=>
    (DMEM_WR_O && DMEM_WDATA_O == $past(acc) && !DMEM_ADDR_O[0]) ##1
    (DMEM_WR_O && DMEM_WDATA_O == $past(ext, 2) && DMEM_ADDR_O[0]))
    else $error("pair store sequence wrong");

  a_move_to_acc : assert property (s_take(nibble_xfer_pkg::OP_MOV_A_REG) |=>
    ACC_O == $past(reg_val) && OP_DONE_O)
    else $error("register to accumulator move wrong");

  a_swap_regs : assert property (s_take(nibble_xfer_pkg::OP_SWAP_REG) ##0 OP_REG_I != 3'h0
    |=> ACC_O == $past(reg_val) && pick(rf_q, $past(reg_idx)) == $past(acc))
    else $error("register exchange wrong");

  a_inc_skip : assert property (s_take(nibble_xfer_pkg::OP_SWAP_IND) ##0
    (OP_PTR_I == nibble_xfer_pkg::PTR_HL_INC && l_now == 4'hF)
    |-> ##4 OP_DONE_O && SKIP_O && l_now == 4'h0)
    else $error("increment wrap did not skip");

  a_dec_skip : assert property (s_take(nibble_xfer_pkg::OP_SWAP_IND) ##0
    (OP_PTR_I == nibble_xfer_pkg::PTR_HL_DEC && l_now != 4'h0)
    |-> ##4 OP_DONE_O && !SKIP_O)
    else $error("decrement skipped too early");

  a_table_page : assert property (s_take(nibble_xfer_pkg::OP_TBL_PC_DE) ##0 last_b
    |=> PMEM_RD_O && PMEM_ADDR_O[12:8] == $past(PC_I[12:8]) + 5'h01)
    else $error("page end lookup not in next page");

  a_adds_carry : assert property (s_take(nibble_xfer_pkg::OP_ADDS_IMM)
    |=> $stable(CARRY_O) && SKIP_O == $past(adds_sum[4]))
    else $error("add with skip handled carry wrong");

  a_squash_quiet : assert property (squash_q && state_q != nibble_xfer_pkg::S_IDLE
    |-> rf_we == 16'h0000 && !DMEM_WR_O ##1 $stable(CARRY_O))
    else $error("skipped operation changed state");

endmodule

// ### tb/mem_model.sv
// Purpose: data and program memory on the far side of the transfer unit
// Assumes: one-cycle read latency, writes land on the strobe edge
// Notes:   idle read data flips so a stale value never passes
`timescale 1ns/1ps
module mem_model (
  // memory buses
  input  wire logic        clk_i,
  input  wire logic [7:0]  da_i,
  input  wire logic        drd_i,
  input  wire logic        dwr_i,
  input  wire logic [3:0]  dwd_i,
  output logic      [3:0]  drd_o = 4'h0,
  input  wire logic [14:0] pa_i,
  input  wire logic        prd_i,
  output logic      [7:0]  pd_o = 8'h00
);
  logic [3:0] dm [256];
  always @(posedge clk_i) begin
    if (dwr_i)
      dm[da_i] <= dwd_i;
    drd_o <= drd_i ? dm[da_i] : ~drd_o;
    pd_o  <= prd_i ? (pa_i[7:0] ^ {1'b0, pa_i[14:8]} ^ 8'h5A) : ~pd_o;
  end
endmodule

// ### tb/tb_top.sv
// Purpose: random and corner checks of the nibble transfer unit
// Assumes: memory preloaded through the model, not through the unit
// Notes:   corners reseed the memory words they depend on
`timescale 1ns/1ps
module tb_top;
  logic                      clk = 1'b0;
  logic                      rst_n = 1'b0;
  logic                      ce = 1'b1;
  logic                      vld = 1'b0;
  nibble_xfer_pkg::op_t      code = nibble_xfer_pkg::OP_NOP;
  nibble_xfer_pkg::ptr_t     ptr = nibble_xfer_pkg::PTR_HL;
  nibble_xfer_pkg::bitmode_t bm = nibble_xfer_pkg::BIT_FMEM;
  logic [2:0]                rg = 3'h0, pr = 3'h0;
  logic [7:0]                ad = 8'h00, s = 8'h38, a, v, w, t, da, pd;
  logic [1:0]                bt = 2'h0;
  logic [3:0]                im = 4'h0, acc, ext, drd, dwd, m;
  logic [12:0]               pc = 13'h0000;
  logic [14:0]               pa;
  logic [4:0]                sum;
  logic                      rdy, done, skp, cy, drs, dwr, prd;
  int                        mismatches = 0, checks = 0;

  nibble_xfer_unit dut_u (.CORE_CLK_I(clk), .ARST_N_I(rst_n), .CE_I(ce), .OP_VALID_I(vld),
    .OP_READY_O(rdy), .OP_CODE_I(code), .OP_REG_I(rg), .OP_PAIR_I(pr), .OP_PTR_I(ptr),
    .OP_BITMODE_I(bm), .OP_ADDR_I(ad), .OP_BIT_I(bt), .OP_IMM_I(im), .PC_I(pc),
    .OP_DONE_O(done), .SKIP_O(skp), .DMEM_ADDR_O(da), .DMEM_RD_O(drs), .DMEM_WR_O(dwr),
    .DMEM_WDATA_O(dwd), .DMEM_RDATA_I(drd), .PMEM_ADDR_O(pa), .PMEM_RD_O(prd),
    .PMEM_RDATA_I(pd), .ACC_O(acc), .EXT_O(ext), .CARRY_O(cy));
  mem_model mem_u (.clk_i(clk), .da_i(da), .drd_i(drs), .dwr_i(dwr), .dwd_i(dwd),
    .drd_o(drd), .pa_i(pa), .prd_i(prd), .pd_o(pd));

  function automatic logic [7:0] nx(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  function automatic logic [7:0] tbyte(input logic [14:0] x);
    return x[7:0] ^ {1'b0, x[14:8]} ^ 8'h5A;
  endfunction
  task automatic cmp(input string nm, input logic [14:0] e, input logic [14:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // request held until the take edge, then wait for the done pulse
  task automatic go(input nibble_xfer_pkg::op_t c);
    int n = 0;
    @(negedge clk);
    cmp("ready", 1'b1, rdy);
    code = c;
    vld = 1'b1;
    @(posedge clk);
    @(negedge clk);
    vld = 1'b0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n == 20)
      mismatches++;
  endtask
  task automatic ld(input logic [7:0] x);
    ad = x;
    go(nibble_xfer_pkg::OP_LD_MEM_PAIR);
  endtask
  task automatic setp(input logic [2:0] p, input logic [7:0] x);
    mem_u.dm[8'hF0] = x[3:0];
    mem_u.dm[8'hF1] = x[7:4];
    ld(8'hF0);
    pr = p;
    go(nibble_xfer_pkg::OP_MOV_PAIR_XA);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial forever #5 clk = ~clk;
  initial begin
    repeat (10000) @(posedge clk);
    mismatches++;
    complete_run();
  end

  initial begin
    for (int i = 0; i < 256; i++) begin
      s = nx(s);
      mem_u.dm[i] = s[3:0];
    end
    mem_u.dm[8'h20] = 4'h4;
    mem_u.dm[8'h21] = 4'h9;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    ad = 8'h20;
    bt = 2'h2;
    go(nibble_xfer_pkg::OP_BIT_LD);
    cmp("bit_ld", 1'b1, cy);
    ad = 8'h21;
    bt = 2'h1;
    go(nibble_xfer_pkg::OP_BIT_ST);
    cmp("bit_st", 4'hB, mem_u.dm[8'h21]);
    repeat (20) begin
      s = nx(s);
      a = {s[7:1], 1'b0};
      v = {mem_u.dm[a + 8'h01], mem_u.dm[a]};
      ld(a);
      cmp("ld_xa", v, {ext, acc});
      s = nx(s);
      ad = s;
      go(nibble_xfer_pkg::OP_ST_MEM);
      cmp("st_a", v[3:0], mem_u.dm[s]);
      ad = {s[7:1], 1'b0};
      go(nibble_xfer_pkg::OP_ST_MEM_PAIR);
      cmp("st_xa", v, {mem_u.dm[ad + 8'h01], mem_u.dm[ad]});
      pr = (s[2:0] == 3'h0) ? 3'h4 : s[2:0];
      go(nibble_xfer_pkg::OP_MOV_PAIR_XA);
      s = nx(s);
      a = {s[7:1], 1'b0};
      w = {mem_u.dm[a + 8'h01], mem_u.dm[a]};
      ld(a);
      go(nibble_xfer_pkg::OP_MOV_XA_PAIR);
      cmp("pair", v, {ext, acc});
      rg = 3'h2 + {1'b0, s[2:1]};
      go(nibble_xfer_pkg::OP_MOV_REG_A);
      ld(a);
      go(nibble_xfer_pkg::OP_SWAP_REG);
      cmp("swap_reg", v[3:0], acc);
      go(nibble_xfer_pkg::OP_MOV_A_REG);
      cmp("mov_a", w[3:0], acc);
      s = nx(s);
      ad = s;
      m = mem_u.dm[s];
      go(nibble_xfer_pkg::OP_SWAP_DIR);
      cmp("swap_dir", {w[3:0], m}, {mem_u.dm[s], acc});
      im = s[7:4];
      sum = {1'b0, m} + {1'b0, im};
      go(nibble_xfer_pkg::OP_ADDS_IMM);
      cmp("adds", {sum, 1'b1}, {skp, acc, cy});
      go(nibble_xfer_pkg::OP_ST_MEM);
      cmp("squash", sum[4] ? w[3:0] : sum[3:0], mem_u.dm[s]);
    end
    setp(3'h1, 8'h3F);
    mem_u.dm[8'h3F] = 4'h7;
    ptr = nibble_xfer_pkg::PTR_HL_INC;
    go(nibble_xfer_pkg::OP_SWAP_IND);
    cmp("inc", 9'h17F, {skp, acc, mem_u.dm[8'h3F]});
    go(nibble_xfer_pkg::OP_MOV_XA_PAIR);
    cmp("squash_mov", 4'h7, acc);
    go(nibble_xfer_pkg::OP_MOV_XA_PAIR);
    cmp("wrap", 9'h030, {skp, ext, acc});
    ptr = nibble_xfer_pkg::PTR_HL_DEC;
    go(nibble_xfer_pkg::OP_SWAP_IND);
    cmp("dec", 1'b1, skp);
    go(nibble_xfer_pkg::OP_NOP);
    go(nibble_xfer_pkg::OP_MOV_XA_PAIR);
    cmp("dec_l", 8'h3F, {ext, acc});
    go(nibble_xfer_pkg::OP_SWAP_IND);
    cmp("dec_noskip", 1'b0, skp);
    setp(3'h2, 8'h6A);
    setp(3'h1, 8'h25);
    mem_u.dm[8'h24] = 4'hC;
    mem_u.dm[8'h25] = 4'h1;
    // freeze while the first read is pending
    fork
      go(nibble_xfer_pkg::OP_SWAP_IND_PAIR);
      begin
        repeat (2) @(negedge clk);
        ce = 1'b0;
        repeat (3) @(negedge clk);
        ce = 1'b1;
      end
    join
    cmp("swap_xa", 8'h1C, {ext, acc});
    cmp("swap_mem", 8'h25, {mem_u.dm[8'h25], mem_u.dm[8'h24]});
    go(nibble_xfer_pkg::OP_SWAP_PAIR);
    cmp("swap_pair", 8'h25, {ext, acc});
    ptr = nibble_xfer_pkg::PTR_DL;
    mem_u.dm[8'h6C] = 4'h8;
    go(nibble_xfer_pkg::OP_SWAP_IND);
    cmp("swap_dl", 8'h85, {acc, mem_u.dm[8'h6C]});
    ptr = nibble_xfer_pkg::PTR_DE;
    mem_u.dm[8'h6A] = 4'h3;
    go(nibble_xfer_pkg::OP_SWAP_IND);
    cmp("swap_de", 8'h38, {acc, mem_u.dm[8'h6A]});
    ad = 8'h50;
    mem_u.dm[8'h50] = 4'h9;
    mem_u.dm[8'h51] = 4'hE;
    go(nibble_xfer_pkg::OP_SWAP_DIR_PAIR);
    cmp("swap_dir_xa", 8'hE9, {ext, acc});
    cmp("swap_dir_mem", 8'h23, {mem_u.dm[8'h51], mem_u.dm[8'h50]});
    bm = nibble_xfer_pkg::BIT_HMEM;
    ad = 8'h07;
    bt = 2'h3;
    mem_u.dm[8'h17] = 4'h7;
    go(nibble_xfer_pkg::OP_BIT_LD);
    cmp("bit_h", 1'b0, cy);
    bm = nibble_xfer_pkg::BIT_PMEM;
    ad = 8'hF0;
    mem_u.dm[8'hF3] = 4'hF;
    go(nibble_xfer_pkg::OP_BIT_ST);
    cmp("bit_p", 4'hE, mem_u.dm[8'hF3]);
    for (int i = 0; i < 2; i++) begin
      pc = 13'h02FE + 13'(i);
      setp(3'h0, 8'h4B);
      go(nibble_xfer_pkg::OP_TBL_PC_XA);
      a = {3'h0, pc[12:8]} + {7'h00, pc[7:0] == 8'hFF};
      cmp("tbl_pc", tbyte({2'h0, a[4:0], 8'h4B}), {ext, acc});
      go(nibble_xfer_pkg::OP_TBL_PC_DE);
      cmp("tbl_de", tbyte({2'h0, a[4:0], 8'h6A}), {ext, acc});
    end
    setp(3'h3, 8'hD6);
    setp(3'h2, 8'h9A);
    t = tbyte(15'h569A);
    go(nibble_xfer_pkg::OP_TBL_BC_DE);
    cmp("tbl_third_second_lookup", t, {ext, acc});
    go(nibble_xfer_pkg::OP_TBL_BC_XA);
    cmp("tbl_third_acc_lookup", tbyte({3'h1, 4'h6, t}), {ext, acc});
    complete_run();
  end
endmodule
